// *** core/ptc_capture.sv ***
// Capture input mode of a ten-bit periodic timer.
// Assumes tick_en is a one-cycle enable from a prescaler on core_clk.
`timescale 1ns/1ps
`default_nettype none
module ptc_capture
#(
  parameter int unsigned TIMER_IDX = 0  // 0 has comparator and clear options
)
(
  // Clock, reset, timer tick
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       tick_en,
  // Control bits
  input  wire logic       op_mode_sel_hi,
  input  wire logic       op_mode_sel_lo,
  input  wire logic       counter_run,
  input  wire logic       cap_src_sel,
  input  wire logic [1:0] input_route_reg,
  input  wire logic       edge_sel_hi,
  input  wire logic       edge_sel_lo,
  input  wire logic       clear_cond_hi,
  input  wire logic       clear_cond_lo,
  input  wire logic [9:0] period_reg,
  // Ignored in this mode
  input  wire logic       clear_sel,
  input  wire logic       out_init_sel,
  input  wire logic       out_invert,
  // Flag clears from software, one-cycle pulses
  input  wire logic       clr_match_a,
  input  wire logic       clr_period,
  // Capture sources
  input  wire logic       cap_in_pin,
  input  wire logic       ext_clk_pin,
  input  wire logic       comparator_cap_sig,
  // Results
  output logic [9:0]      count_val,
  output logic [9:0]      compare_a_reg,
  output logic [9:0]      compare_b_reg,
  output logic            match_a_flag,
  output logic            period_match_flag,
  output logic            edge_level_flag,
  output logic            timer_out
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic pin_s;   // Capture pin, synchronised
  logic clk_s;   // Clock pin, synchronised
  logic cmp_s;   // Comparator, synchronised

  ptc_sync u_sync_pin (.core_clk(core_clk), .reset_n(reset_n), .async_in(cap_in_pin), .sync_out(pin_s));
  ptc_sync u_sync_clk (.core_clk(core_clk), .reset_n(reset_n), .async_in(ext_clk_pin), .sync_out(clk_s));
  ptc_sync u_sync_cmp (.core_clk(core_clk), .reset_n(reset_n), .async_in(comparator_cap_sig),
                       .sync_out(cmp_s));

  // ----------------------------------------
  // Source selection and edge detect
  // ----------------------------------------
  logic       pin_path;        // Pin path after routing
  logic       src;             // Selected capture source
  logic       src_ff;          // Previous tick-sampled level
  logic       samp_ff;         // Source sampled on timer tick
  logic       rise;            // Rising edge on a tick
  logic       fall;            // Falling edge on a tick
  logic [1:0] edge_sel;        // Edge select field
  logic [1:0] clr_cond;        // Clear condition field
  logic       cap_mode;        // Capture mode selected
  logic       run_ff;          // Run bit delayed
  logic       cap_hit;         // Active capture edge
  logic       clr_hit;         // Edge-driven counter clear
  logic       per_hit;         // Period compare match
  logic       to_b;            // Capture lands in B

  assign pin_path = (TIMER_IDX == ptc_pkg::TIMER_ZERO && input_route_reg == ptc_pkg::ROUTE_CMP)
                    ? cmp_s : pin_s;
  assign src      = cap_src_sel ? clk_s : pin_path;
  assign edge_sel = {edge_sel_hi, edge_sel_lo};
  assign clr_cond = (TIMER_IDX == ptc_pkg::TIMER_ZERO) ? {clear_cond_hi, clear_cond_lo} : ptc_pkg::CLR_NONE;
  assign cap_mode = ({op_mode_sel_hi, op_mode_sel_lo} == ptc_pkg::MODE_CAPTURE);
  // Edges are judged on timer ticks: a pulse shorter than one tick may slip by
  assign rise     = tick_en && samp_ff && !src_ff;
  assign fall     = tick_en && !samp_ff && src_ff;

  // Edge select gates capture only; clear condition gates reset and steers falling-edge captures to B
  assign cap_hit  = cap_mode && counter_run && ((edge_sel == ptc_pkg::EDGE_RISE && rise)
                    || (edge_sel == ptc_pkg::EDGE_FALL && fall)
                    || (edge_sel == ptc_pkg::EDGE_BOTH && (rise || fall)));
  assign clr_hit  = cap_mode && counter_run && ((clr_cond == ptc_pkg::CLR_RISE && rise)
                    || (clr_cond == ptc_pkg::CLR_FALL && fall)
                    || (clr_cond == ptc_pkg::CLR_BOTH && (rise || fall)));
  // Zero period never matches, so the counter wraps at full range
  assign per_hit  = cap_mode && counter_run && tick_en && (period_reg != ptc_pkg::CNT_RST)
                    && (count_val == period_reg);
  // Timer 0 with a clear condition: falling edge goes to B, rising to A
  assign to_b     = (TIMER_IDX == ptc_pkg::TIMER_ZERO) && (clr_cond != ptc_pkg::CLR_NONE) && fall;

  // ----------------------------------------
  // Edge sampling on timer tick
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      samp_ff <= 1'b0;
      src_ff  <= 1'b0;
    end
    else if (tick_en)
    begin
      samp_ff <= src;
      src_ff  <= samp_ff;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [9:0] nxt_count;  // Next counter value

  assign nxt_count = (!counter_run || (counter_run && !run_ff)) ? ptc_pkg::CNT_RST
                     : (per_hit || (clr_hit)) ? ptc_pkg::CNT_RST
                     : tick_en ? count_val + 10'h001 : count_val;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_val <= ptc_pkg::CNT_RST;
      run_ff    <= 1'b0;
    end
    else
    begin
      count_val <= cap_mode ? nxt_count : ptc_pkg::CNT_RST;
      run_ff    <= counter_run;
    end
  end

  // ----------------------------------------
  // Capture registers and flags
  // ----------------------------------------
  logic lvl_pend_ff;  // Level flag update held one core cycle
  logic lvl_val_ff;   // Edge polarity waiting to land

  // Latch occurs on the tick after the sampled edge, well inside 1.5 ticks
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      compare_a_reg <= ptc_pkg::CNT_RST;
      compare_b_reg <= ptc_pkg::CNT_RST;
    end
    else if (cap_hit && to_b)
    begin
      compare_b_reg <= count_val;
    end
    else if (cap_hit)
    begin
      compare_a_reg <= count_val;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      match_a_flag      <= 1'b0;
      period_match_flag <= 1'b0;
    end
    else
    begin
      match_a_flag      <= cap_hit | (match_a_flag & ~clr_match_a);
      period_match_flag <= per_hit | (period_match_flag & ~clr_period);
    end
  end

  // Level flag trails the match flag by one core cycle, standing in for half a tick
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lvl_pend_ff     <= 1'b0;
      lvl_val_ff      <= 1'b0;
      edge_level_flag <= 1'b0;
    end
    else
    begin
      lvl_pend_ff <= cap_hit;
      if (cap_hit)
      begin
        lvl_val_ff <= rise;
      end
      if (lvl_pend_ff)
      begin
        edge_level_flag <= lvl_val_ff;
      end
    end
  end

  // ----------------------------------------
  // Output pin: idle in capture mode
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_out <= 1'b0;
    end
    else
    begin
      timer_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_period_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    per_hit |=> (count_val == ptc_pkg::CNT_RST) && period_match_flag)
    else $error("period match did not clear counter");
  a_capture_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cap_hit && !to_b) |=> (compare_a_reg == $past(count_val)) && match_a_flag)
    else $error("capture did not latch A");
  a_capture_b: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cap_hit && to_b) |=> (compare_b_reg == $past(count_val)) && match_a_flag)
    else $error("capture did not latch B");
  // Level flag must carry the polarity of the edge two clocks back, not just any value
  a_level_late: assert property (@(posedge core_clk) disable iff (!reset_n)
    cap_hit |=> ##1 (edge_level_flag == $past(rise, 2)))
    else $error("level flag not updated");
  a_no_cap_none: assert property (@(posedge core_clk) disable iff (!reset_n)
    (edge_sel == ptc_pkg::EDGE_NONE) |-> !cap_hit)
    else $error("capture with edges disabled");
  a_stop_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !counter_run |=> (count_val == ptc_pkg::CNT_RST))
    else $error("counter ran while stopped");
  a_out_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
    !timer_out)
    else $error("output driven in capture mode");
  a_zero_period: assert property (@(posedge core_clk) disable iff (!reset_n)
    (period_reg == ptc_pkg::CNT_RST) |-> !per_hit)
    else $error("match with zero period");
  a_full_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cap_mode && counter_run && run_ff && tick_en && !clr_hit && (period_reg == ptc_pkg::CNT_RST)
     && (count_val == ptc_pkg::CNT_MAX)) |=> (count_val == ptc_pkg::CNT_RST))
    else $error("counter did not wrap at full range");
  a_edge_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    clr_hit |=> (count_val == ptc_pkg::CNT_RST))
    else $error("edge clear ignored");
endmodule : ptc_capture
`default_nettype wire

// *** core/ptc_pkg.sv ***
// Constants shared by the capture-mode periodic timer.
// Assumes one core clock; timer tick arrives as an enable pulse.
package ptc_pkg;
  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int unsigned CNT_W = 10;                     // Counter width
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;         // Full count
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;         // Reset value
  localparam logic [1:0] MODE_CAPTURE = 2'h1;             // Operating mode code
  localparam logic [1:0] EDGE_RISE = 2'h0;                // Edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;
  localparam logic [1:0] CLR_NONE = 2'h0;                 // Clear condition codes
  localparam logic [1:0] CLR_RISE = 2'h1;
  localparam logic [1:0] CLR_FALL = 2'h2;
  localparam logic [1:0] CLR_BOTH = 2'h3;
  localparam logic [1:0] ROUTE_PIN = 2'h0;                // Input routing: pin
  localparam logic [1:0] ROUTE_CMP = 2'h1;                // Input routing: comparator
  localparam int unsigned TIMER_ZERO = 0;                 // Timer 0 index
endpackage : ptc_pkg

// *** core/ptc_sync.sv ***
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a pin or another domain.
`timescale 1ns/1ps
`default_nettype none
module ptc_sync
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;  // First stage, read only by the second

  // ----------------------------------------
  // Synchroniser stages
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : ptc_sync
`default_nettype wire

// *** test/ptc_pulse_src.sv ***
// Far-side pulse source for the capture timer: pin, clock pin, comparator.
// Assumes the bench sets the level and which source is in use.
`timescale 1ns/1ps
`default_nettype none
module ptc_pulse_src
(
  // Stimulus from the bench
  input  wire logic       level,
  input  wire logic [1:0] pick,
  // Capture sources
  output logic            cap_in_pin,
  output logic            ext_clk_pin,
  output logic            comparator_cap_sig
);
  // Unused sources rest low, like pulled-down pins, so a wrong select sees no edge
  // and switching sources at a low level makes no false edge
  assign cap_in_pin         = (pick == 2'h0) ? level : 1'b0;
  assign ext_clk_pin        = (pick == 2'h1) ? level : 1'b0;
  assign comparator_cap_sig = (pick == 2'h2) ? level : 1'b0;
endmodule : ptc_pulse_src
`default_nettype wire

// *** test/tb_periodic_timer_capture_mode.sv ***
// Self-checking bench for the capture-mode timer, timer 0 build.
// Assumes a tick on every core clock outside the half-rate test.
`timescale 1ns/1ps
`default_nettype none
module tb_periodic_timer_capture_mode;
  logic       core_clk, reset_n, run, src, cma, cpr, lvl;
  logic [1:0] mode, edg, clr, route, pick;
  logic [9:0] per, cnt, ca, cb, a1, top, np;
  logic       fa, fp, fl, tout, pin, ck, cmp, bad, tick, slow;
  int         failures, total_checks, cyc;
  // Far side and device
  ptc_pulse_src src_u (.level(lvl), .pick(pick), .cap_in_pin(pin), .ext_clk_pin(ck),
                       .comparator_cap_sig(cmp));
  ptc_capture #(.TIMER_IDX(0)) dut_u (.core_clk(core_clk), .reset_n(reset_n), .tick_en(tick),
    .op_mode_sel_hi(mode[1]), .op_mode_sel_lo(mode[0]), .counter_run(run), .cap_src_sel(src),
    .input_route_reg(route), .edge_sel_hi(edg[1]), .edge_sel_lo(edg[0]), .clear_cond_hi(clr[1]),
    .clear_cond_lo(clr[0]), .period_reg(per), .clear_sel(1'b1), .out_init_sel(1'b1),
    .out_invert(1'b1), .clr_match_a(cma), .clr_period(cpr), .cap_in_pin(pin), .ext_clk_pin(ck),
    .comparator_cap_sig(cmp), .count_val(cnt), .compare_a_reg(ca), .compare_b_reg(cb),
    .match_a_flag(fa), .period_match_flag(fp), .edge_level_flag(fl), .timer_out(tout));
  // Clock, 25 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Timer tick: every clock, or every second clock while slow is set
  always @(posedge core_clk)
  begin
    tick <= slow ? ~tick : 1'b1;
  end
  // Hang guard: ceiling well above the fifteen hundred cycles the tests need
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tk
  // Move the source level, then leave it alone for gap cycles
  task automatic edge_to(input logic v, input int gap);
    @(posedge core_clk) lvl <= v;
    tk(gap);
  endtask : edge_to
  // One-cycle clear pulses on both flags
  task automatic clr_flags();
    @(posedge core_clk)
    begin
      cma <= 1'b1;
      cpr <= 1'b1;
    end
    @(posedge core_clk)
    begin
      cma <= 1'b0;
      cpr <= 1'b0;
    end
  endtask : clr_flags
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset_n, run, src, cma, cpr, lvl, tick, slow, failures, total_checks, cyc} = '0;
    mode = ptc_pkg::MODE_CAPTURE;
    edg = ptc_pkg::EDGE_RISE;
    clr = ptc_pkg::CLR_NONE;
    route = ptc_pkg::ROUTE_PIN;
    pick = 2'h0;
    per = 10'h000;
    tk(6);
    reset_n <= 1'b1;
    check("reset a", ca, 10'h000);
    check("reset b", cb, 10'h000);
    check("reset flags", {6'h00, fa, fp, fl, tout}, 10'h000);
    @(posedge core_clk) run <= 1'b1;
    tk(5);
    // Rising edges only: spacing between captures equals edge spacing
    edge_to(1'b1, 20);
    check("flag a", {9'h000, fa}, 10'h001);
    a1 = ca;
    clr_flags();
    edge_to(1'b0, 20);
    check("fall ignored", {9'h000, fa}, 10'h000);
    edge_to(1'b1, 20);
    check("capture step", ca - a1, 10'd44);
    check("b untouched", cb, 10'h000);
    check("no period flag", {9'h000, fp}, 10'h000);
    check("no output", {9'h000, tout}, 10'h000);
    $display("test rise done");
    // Edge code 11: no capture, counter still runs
    edg <= ptc_pkg::EDGE_NONE;
    clr_flags();
    edge_to(1'b0, 20);
    edge_to(1'b1, 20);
    check("none no flag", {9'h000, fa}, 10'h000);
    a1 = cnt;
    tk(10);
    check("still counts", cnt - a1, 10'd10);
    // Tick on every second clock: the counter follows the tick, not the clock
    slow <= 1'b1;
    tk(2);
    a1 = cnt;
    tk(20);
    check("half tick rate", cnt - a1, 10'd10);
    slow <= 1'b0;
    // Park the source low so the source switches below make no edge
    edge_to(1'b0, 20);
    $display("test none done");
    // Every source with both edges; a wrong select sees a quiet source
    edg <= ptc_pkg::EDGE_BOTH;
    for (int k = 0; k < 3; k++)
    begin
      src   <= (k == 1);
      route <= (k == 2) ? ptc_pkg::ROUTE_CMP : ptc_pkg::ROUTE_PIN;
      pick  <= k[1:0];
      clr_flags();
      edge_to(1'b1, 20);
      check("source capture", {9'h000, fa}, 10'h001);
      edge_to(1'b0, 20);
    end
    $display("test sources done");
    // Clear on rise: rise goes to A, fall to B with the width
    src   <= 1'b0;
    route <= ptc_pkg::ROUTE_PIN;
    pick  <= 2'h0;
    clr   <= ptc_pkg::CLR_RISE;
    clr_flags();
    edge_to(1'b1, 30);
    // Level flag is looked at here and after reset; every capture updates it
    check("level rise", {9'h000, fl}, 10'h001);
    edge_to(1'b0, 30);
    check("width in b", {9'h000, cb >= 10'd29 && cb <= 10'd31}, 10'h001);
    check("level fall", {9'h000, fl}, 10'h000);
    $display("test clear done");
    // Period limit: restart so the count starts below the period
    run <= 1'b0;
    clr <= ptc_pkg::CLR_NONE;
    per <= 10'h010;
    tk(2);
    check("stop clears", cnt, 10'h000);
    run <= 1'b1;
    clr_flags();
    {bad, np, top} = '0;
    // Software clears each period flag and counts the matches
    repeat (60)
    begin
      @(posedge core_clk);
      if (cnt > per)
        bad = 1'b1;
      if (cnt > top)
        top = cnt;
      if (fp && !cpr)
        np++;
      cpr <= fp && !cpr;
    end
    // Let one more match land with no clear pending
    tk(17);
    check("count bound", {9'h000, bad}, 10'h000);
    check("count top", top, 10'h010);
    check("period count", np, 10'd3);
    check("period flag", {9'h000, fp}, 10'h001);
    check("a flag quiet", {9'h000, fa}, 10'h000);
    $display("test period done");
    // Zero period: a full lap of 1024 ticks brings the count back
    per <= 10'h000;
    tk(2);
    a1 = cnt;
    tk(1024);
    check("full wrap", cnt, a1);
    $display("test wrap done");
    give_verdict();
  end
endmodule : tb_periodic_timer_capture_mode
`default_nettype wire
